// ===== rtl/sdls_consts.vh
/*
 * constants of the stored data link sequencer: register map, field layout of
 * an operation data entry, link modes, operation kinds and timing.
 * assumes it is included once per design file by its bare name.
 */
// Summary of operation
// - positioning modes advance on target reached, next-step input, or event jump.
// - continuous velocity mode advances only on next-step input or event jump.
// - a no-link entry runs once and then the sequence ends.
// - sequential-start while sequence busy runs the current entry's next number.
// - sequential-start while not busy runs the entry chosen by the selection.
// - start drops ready, raises sequence busy and begins motion.
// - manual mode: after each entry, ready high while sequence busy stays high.
// - sequential-start is released once ready drops, showing the entry started.
// - after the last linked entry, sequence busy low and ready high.
// - automatic mode waits the entry's dwell in ms, then starts next entry.
// - automatic and continuous chains run on until a no-link entry finishes.
// - continuous sequential mode switches entries without stopping the motor.
// - continuous mode on target ramps present velocity to next target velocity.
// - on linking onward, use the acceleration time of the new entry.
// - opposite direction next entry decelerates with next entry's deceleration time.
// - final stop decelerates with the last linked entry's deceleration time.
// - chain start entry comes from binary or direct selection inputs.
// - binary selection is the eight-bit value of the inputs, 0 to 255.
// - entry priority: remote selection, then direct selection, then binary.
`ifndef SDLS_CONSTS_VH
`define SDLS_CONSTS_VH

// register byte offsets
`define SDLS_REG_CTRL 8'h00
`define SDLS_REG_STATUS 8'h04
`define SDLS_REG_TAB_ADDR 8'h08
`define SDLS_REG_TAB_DATA 8'h0C
`define SDLS_REG_REMOTE_SEL 8'h10
`define SDLS_REG_DIRECT_MAP 8'h14
`define SDLS_REG_ACTIVE 8'h18

// ctrl fields
`define SDLS_CTRL_ENABLE_BIT 0
`define SDLS_CTRL_RESET 32'h0000_0001

// entry word layout (32 bits)
`define SDLS_ENT_LINK_LSB 0
`define SDLS_ENT_NEXT_LSB 2
`define SDLS_ENT_KIND_BIT 10
`define SDLS_ENT_DIR_BIT 11
`define SDLS_ENT_DWELL_LSB 12
`define SDLS_ENT_DWELL_W 16
`define SDLS_ENT_ACC_LSB 28
`define SDLS_ENT_DEC_LSB 30
`define SDLS_ENT_RESET 32'h0000_0000

// link modes
`define SDLS_LINK_NONE 2'h0
`define SDLS_LINK_MANUAL 2'h1
`define SDLS_LINK_AUTO 2'h2
`define SDLS_LINK_CONT 2'h3

// operation kind
`define SDLS_KIND_POSITION 1'b0
`define SDLS_KIND_VELOCITY 1'b1

// remote selection disabled value (out of 0..255)
`define SDLS_REMOTE_RESET 32'h0000_0100

// timing
`define SDLS_CLK_HZ 50000000
`define SDLS_MS_PER_S 1000
`define SDLS_CYC_PER_MS ((`SDLS_CLK_HZ) / (`SDLS_MS_PER_S))

`endif

// ===== rtl/sdls_entry_mem.v
/*
 * operation data table: one 32-bit word per entry, registered read data.
 * assumes a single clock and synchronous single-port write.
 */
`timescale 1ns/1ps
`default_nettype none
module sdls_entry_mem #(
	parameter ADDR_W = 8,
	parameter DATA_W = 32
) (
	input wire clk_i,
	input wire wr_en_i,
	input wire [ADDR_W-1:0] wr_addr_i,
	input wire [DATA_W-1:0] wr_data_i,
	input wire [ADDR_W-1:0] rd_addr_i,
	output reg [DATA_W-1:0] rd_data_o
);
	reg [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

	always @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_reg[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem_reg[rd_addr_i];
	end
endmodule // sdls_entry_mem
`default_nettype wire

// ===== rtl/sdls_sequencer.v
/*
 * stored data link sequencer: picks the start entry, runs linked entries of
 * the operation data table and drives ready and sequence-busy to the host.
 * assumes a profile generator that takes a launch pulse with entry number and
 * ramp selections, and reports target reached and motion stopped.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sdls_consts.vh"
module sdls_sequencer #(
	parameter CYC_PER_MS = `SDLS_CYC_PER_MS
) (
	// clock and reset
	input wire CLK_I,
	input wire ARST_N_I,
	// avalon-mm slave
	input wire [7:0] AVS_ADDRESS_I,
	input wire AVS_READ_I,
	input wire AVS_WRITE_I,
	input wire [31:0] AVS_WRITEDATA_I,
	input wire [3:0] AVS_BYTEENABLE_I,
	output reg [31:0] AVS_READDATA_O,
	output wire AVS_WAITREQUEST_O,
	// host discrete inputs
	input wire START_IN_I,
	input wire SEQUENTIAL_START_IN_I,
	input wire NEXT_STEP_IN_I,
	input wire STOP_IN_I,
	input wire [7:0] BINARY_ENTRY_SELECT_IN_I,
	input wire [15:0] DIRECT_ENTRY_SELECT_IN_I,
	// host discrete outputs
	output reg STORED_OP_READY_OUT_O,
	output reg SEQUENCE_BUSY_OUT_O,
	// profile generator side
	input wire EVENT_JUMP_I,
	input wire TARGET_REACHED_I,
	input wire MOTION_STOPPED_I,
	output reg LAUNCH_O,
	output reg [7:0] ENTRY_O,
	output reg [7:0] ACCEL_ENTRY_O,
	output reg [7:0] DECEL_ENTRY_O,
	output reg STOP_REQ_O,
	output reg RAMP_ON_FLY_O
);
	// ==========================================================
	// states
	localparam ST_IDLE = 3'd0;
	localparam ST_FETCH = 3'd1;
	localparam ST_LAUNCH = 3'd2;
	localparam ST_RUN = 3'd3;
	localparam ST_STOPPING = 3'd4;
	localparam ST_DWELL = 3'd5;
	localparam ST_MANWAIT = 3'd6;

	// ==========================================================
	// reset release
	reg rst_s1_reg;
	reg rst_s2_reg;
	wire rst_n;
	always @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst_n = rst_s2_reg;

	// ==========================================================
	// pin synchronisers: three flops, change accepted when 2nd and 3rd agree
	localparam NPIN = 28;
	wire [NPIN-1:0] pin_raw;
	reg [NPIN-1:0] pin_s1_reg;
	reg [NPIN-1:0] pin_s2_reg;
	reg [NPIN-1:0] pin_s3_reg;
	reg [NPIN-1:0] pin_reg;
	assign pin_raw = {DIRECT_ENTRY_SELECT_IN_I, BINARY_ENTRY_SELECT_IN_I,
		STOP_IN_I, NEXT_STEP_IN_I, SEQUENTIAL_START_IN_I, START_IN_I};
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
			always @(posedge CLK_I or negedge rst_n) begin
				if (!rst_n) begin
					pin_s1_reg[gi] <= 1'b0;
					pin_s2_reg[gi] <= 1'b0;
					pin_s3_reg[gi] <= 1'b0;
					pin_reg[gi] <= 1'b0;
				end else begin
					pin_s1_reg[gi] <= pin_raw[gi];
					pin_s2_reg[gi] <= pin_s1_reg[gi];
					pin_s3_reg[gi] <= pin_s2_reg[gi];
					if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
						pin_reg[gi] <= pin_s3_reg[gi];
					end
				end
			end
		end
	endgenerate
	wire start_lvl = pin_reg[0];
	wire sequential_start_in_lvl = pin_reg[1];
	wire next_lvl = pin_reg[2];
	wire stop_lvl = pin_reg[3];
	wire [7:0] bin_sel = pin_reg[11:4];
	wire [15:0] dir_sel = pin_reg[27:12];
	reg start_d_reg;
	reg sequential_start_in_d_reg;
	reg next_d_reg;
	wire start_rise = start_lvl & ~start_d_reg;
	wire sequential_start_in_rise = sequential_start_in_lvl & ~sequential_start_in_d_reg;
	wire next_rise = next_lvl & ~next_d_reg;

	// ==========================================================
	// registers
	reg ctrl_enable_reg;
	reg [7:0] tab_addr_reg;
	reg [8:0] remote_sel_reg;
	reg [127:0] direct_map_reg;
	reg [3:0] direct_idx_reg;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [7:0] cur_reg;
	reg [31:0] ent_reg;
	reg [15:0] dwell_ms_reg;
	reg [15:0] ms_cnt_reg;

	// one-hot check: true when exactly one direct input is on
	function one_hot16;
		input [15:0] v;
		integer k;
		integer n;
		begin
			n = 0;
			for (k = 0; k < 16; k = k + 1) begin
				n = n + v[k];
			end
			one_hot16 = (n == 1);
		end
	endfunction

	function [3:0] hot_index;
		input [15:0] v;
		integer k;
		begin
			hot_index = 4'h0;
			for (k = 0; k < 16; k = k + 1) begin
				if (v[k]) begin
					hot_index = k[3:0];
				end
			end
		end
	endfunction

	// start entry: remote, then direct, then binary
	reg [7:0] sel_entry;
	always @* begin
		if (!remote_sel_reg[8]) begin
			sel_entry = remote_sel_reg[7:0];
		end else if (one_hot16(dir_sel)) begin
			sel_entry = direct_map_reg[hot_index(dir_sel)*8 +: 8];
		end else begin
			sel_entry = bin_sel;
		end
	end

	// ==========================================================
	// avalon slave: fixed one wait state on each access
	wire bus_req = AVS_READ_I | AVS_WRITE_I;
	reg bus_ack_reg;
	assign AVS_WAITREQUEST_O = bus_req & ~bus_ack_reg;
	wire wr_go = AVS_WRITE_I & bus_ack_reg;
	wire [31:0] be_mask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
		{8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
	wire mem_we = wr_go & (AVS_ADDRESS_I == `SDLS_REG_TAB_DATA);
	wire [31:0] mem_rd;
	wire [7:0] mem_raddr = (state_reg == ST_IDLE) ? tab_addr_reg : cur_reg;

	sdls_entry_mem #(
		.ADDR_W(8),
		.DATA_W(32)
	) u_mem (
		.clk_i(CLK_I),
		.wr_en_i(mem_we),
		.wr_addr_i(tab_addr_reg),
		.wr_data_i(AVS_WRITEDATA_I),
		.rd_addr_i(mem_raddr),
		.rd_data_o(mem_rd)
	);

	always @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			bus_ack_reg <= 1'b0;
			AVS_READDATA_O <= 32'h0000_0000;
			ctrl_enable_reg <= 1'b1;
			tab_addr_reg <= 8'h00;
			remote_sel_reg <= 9'h100;
			direct_map_reg <= {8'h0F, 8'h0E, 8'h0D, 8'h0C, 8'h0B, 8'h0A, 8'h09, 8'h08,
				8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00};
			direct_idx_reg <= 4'h0;
		end else begin
			bus_ack_reg <= bus_req & ~bus_ack_reg;
			if (wr_go) begin
				case (AVS_ADDRESS_I)
				`SDLS_REG_CTRL: ctrl_enable_reg <= AVS_WRITEDATA_I[`SDLS_CTRL_ENABLE_BIT];
				`SDLS_REG_TAB_ADDR: tab_addr_reg <= AVS_WRITEDATA_I[7:0];
				`SDLS_REG_REMOTE_SEL: remote_sel_reg <= (AVS_WRITEDATA_I[31:8] != 24'h0)
					? 9'h100 : {1'b0, AVS_WRITEDATA_I[7:0]};
				`SDLS_REG_DIRECT_MAP: begin
					direct_idx_reg <= AVS_WRITEDATA_I[11:8];
					direct_map_reg[AVS_WRITEDATA_I[11:8]*8 +: 8] <= AVS_WRITEDATA_I[7:0];
				end
				default: ;
				endcase
			end
			if (AVS_READ_I & ~bus_ack_reg) begin
				case (AVS_ADDRESS_I)
				`SDLS_REG_CTRL: AVS_READDATA_O <= {31'h0, ctrl_enable_reg};
				`SDLS_REG_STATUS: AVS_READDATA_O <= {24'h0, 3'h0, state_reg,
					SEQUENCE_BUSY_OUT_O, STORED_OP_READY_OUT_O};
				`SDLS_REG_TAB_ADDR: AVS_READDATA_O <= {24'h0, tab_addr_reg};
				`SDLS_REG_TAB_DATA: AVS_READDATA_O <= mem_rd & be_mask;
				`SDLS_REG_REMOTE_SEL: AVS_READDATA_O <= {23'h0, remote_sel_reg};
				`SDLS_REG_DIRECT_MAP: AVS_READDATA_O <= {20'h0, direct_idx_reg,
					direct_map_reg[direct_idx_reg*8 +: 8]};
				`SDLS_REG_ACTIVE: AVS_READDATA_O <= {24'h0, cur_reg};
				default: AVS_READDATA_O <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// entry fields
	wire [1:0] ent_link = ent_reg[`SDLS_ENT_LINK_LSB +: 2];
	wire [7:0] ent_next = ent_reg[`SDLS_ENT_NEXT_LSB +: 8];
	wire ent_kind = ent_reg[`SDLS_ENT_KIND_BIT];
	wire ent_dir = ent_reg[`SDLS_ENT_DIR_BIT];
	wire [15:0] ent_dwell = ent_reg[`SDLS_ENT_DWELL_LSB +: `SDLS_ENT_DWELL_W];
	reg prev_dir_reg;
	reg on_fly_reg;

	// advance condition by operation kind
	wire advance = (ent_kind == `SDLS_KIND_POSITION)
		? (TARGET_REACHED_I | next_rise | EVENT_JUMP_I)
		: (next_rise | EVENT_JUMP_I);

	// ==========================================================
	// sequencer state machine
	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE: begin
			if (ctrl_enable_reg & (start_rise | sequential_start_in_rise)) begin
				state_next = ST_FETCH;
			end
		end
		ST_FETCH: state_next = ST_LAUNCH;
		ST_LAUNCH: state_next = ST_RUN;
		ST_RUN: begin
			if (stop_lvl) begin
				state_next = ST_STOPPING;
			end else if (advance) begin
				if (ent_link == `SDLS_LINK_CONT) begin
					state_next = ST_FETCH;
				end else begin
					state_next = ST_STOPPING;
				end
			end
		end
		ST_STOPPING: begin
			if (MOTION_STOPPED_I) begin
				case (ent_link)
				`SDLS_LINK_AUTO: state_next = ST_DWELL;
				`SDLS_LINK_MANUAL: state_next = ST_MANWAIT;
				default: state_next = ST_IDLE;
				endcase
				if (stop_lvl) begin
					state_next = ST_IDLE;
				end
			end
		end
		ST_DWELL: begin
			if (dwell_ms_reg == 16'h0000) begin
				state_next = ST_FETCH;
			end
		end
		ST_MANWAIT: begin
			if (stop_lvl) begin
				state_next = ST_IDLE;
			end else if (sequential_start_in_rise) begin
				state_next = ST_FETCH;
			end
		end
		default: state_next = ST_IDLE;
		endcase
	end

	always @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			cur_reg <= 8'h00;
			ent_reg <= `SDLS_ENT_RESET;
			dwell_ms_reg <= 16'h0000;
			ms_cnt_reg <= 16'h0000;
			start_d_reg <= 1'b0;
			sequential_start_in_d_reg <= 1'b0;
			next_d_reg <= 1'b0;
			prev_dir_reg <= 1'b0;
			on_fly_reg <= 1'b0;
			STORED_OP_READY_OUT_O <= 1'b1;
			SEQUENCE_BUSY_OUT_O <= 1'b0;
			LAUNCH_O <= 1'b0;
			ENTRY_O <= 8'h00;
			ACCEL_ENTRY_O <= 8'h00;
			DECEL_ENTRY_O <= 8'h00;
			STOP_REQ_O <= 1'b0;
			RAMP_ON_FLY_O <= 1'b0;
		end else begin
			state_reg <= state_next;
			start_d_reg <= start_lvl;
			sequential_start_in_d_reg <= sequential_start_in_lvl;
			next_d_reg <= next_lvl;
			LAUNCH_O <= 1'b0;
			STOP_REQ_O <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				STORED_OP_READY_OUT_O <= 1'b1;
				SEQUENCE_BUSY_OUT_O <= 1'b0;
				on_fly_reg <= 1'b0;
				if (state_next == ST_FETCH) begin
					cur_reg <= sel_entry;
					STORED_OP_READY_OUT_O <= 1'b0;
					SEQUENCE_BUSY_OUT_O <= 1'b1;
				end
			end
			ST_FETCH: ;
			ST_LAUNCH: begin
				ent_reg <= mem_rd;
				LAUNCH_O <= 1'b1;
				ENTRY_O <= cur_reg;
				ACCEL_ENTRY_O <= cur_reg;
				// reversal on the fly brakes with the new entry's deceleration
				DECEL_ENTRY_O <= (on_fly_reg & (mem_rd[`SDLS_ENT_DIR_BIT] != prev_dir_reg))
					? cur_reg : DECEL_ENTRY_O;
				RAMP_ON_FLY_O <= on_fly_reg;
				if (!on_fly_reg) begin
					DECEL_ENTRY_O <= cur_reg;
				end
			end
			ST_RUN: begin
				if (state_next == ST_FETCH) begin
					cur_reg <= ent_next;
					prev_dir_reg <= ent_dir;
					on_fly_reg <= 1'b1;
				end else if (state_next == ST_STOPPING) begin
					STOP_REQ_O <= 1'b1;
					DECEL_ENTRY_O <= cur_reg;
				end
			end
			ST_STOPPING: begin
				on_fly_reg <= 1'b0;
				if (state_next == ST_DWELL) begin
					dwell_ms_reg <= ent_dwell;
					ms_cnt_reg <= 16'h0000;
				end else if (state_next == ST_MANWAIT) begin
					STORED_OP_READY_OUT_O <= 1'b1;
				end
				if (state_next != ST_STOPPING) begin
					cur_reg <= ent_next;
				end
			end
			ST_DWELL: begin
				if (ms_cnt_reg == CYC_PER_MS - 1) begin
					ms_cnt_reg <= 16'h0000;
					if (dwell_ms_reg != 16'h0000) begin
						dwell_ms_reg <= dwell_ms_reg - 16'h0001;
					end
				end else begin
					ms_cnt_reg <= ms_cnt_reg + 16'h0001;
				end
			end
			ST_MANWAIT: begin
				if (state_next == ST_FETCH) begin
					STORED_OP_READY_OUT_O <= 1'b0;
				end
			end
			default: ;
			endcase
		end
	end
endmodule // sdls_sequencer
`default_nettype wire

// ===== tb/sdls_sequencer_sva.sv
/* port checker of the stored data link sequencer.
   assumes it is bound to every sdls_sequencer instance. */
`timescale 1ns/1ps
`default_nettype none
module sdls_sequencer_sva (
	// clock and reset
	input wire CLK_I,
	input wire ARST_N_I,
	// bus
	input wire AVS_READ_I,
	input wire AVS_WRITE_I,
	input wire [31:0] AVS_READDATA_O,
	input wire AVS_WAITREQUEST_O,
	// host and profile side
	input wire STORED_OP_READY_OUT_O,
	input wire SEQUENCE_BUSY_OUT_O,
	input wire LAUNCH_O,
	input wire STOP_REQ_O,
	input wire RAMP_ON_FLY_O
);
	// ====
	// properties
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!ARST_N_I);
	sequence s_ready_drop;
		$fell(STORED_OP_READY_OUT_O);
	endsequence
	sequence s_launch_late;
		##2 LAUNCH_O;
	endsequence
	chk_wait_one: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
		|=> !AVS_WAITREQUEST_O) else $error("bus wait longer than one cycle");
	chk_rd_stands: assert property (!AVS_READ_I |=> $stable(AVS_READDATA_O))
		else $error("read data changed without a read");
	chk_launch_seq: assert property (s_ready_drop |-> s_launch_late)
		else $error("no launch after ready fell");
	chk_launch_busy: assert property (LAUNCH_O |-> SEQUENCE_BUSY_OUT_O && !STORED_OP_READY_OUT_O)
		else $error("launch outside a busy sequence");
	chk_busy_rise: assert property ($rose(SEQUENCE_BUSY_OUT_O) |-> !STORED_OP_READY_OUT_O)
		else $error("busy rose with ready high");
	chk_end_ready: assert property ($fell(SEQUENCE_BUSY_OUT_O) |-> STORED_OP_READY_OUT_O)
		else $error("sequence ended without ready");
	chk_ready_idle: assert property (STORED_OP_READY_OUT_O |-> !LAUNCH_O)
		else $error("launch while ready high");
	chk_stop_busy: assert property (STOP_REQ_O |-> !STORED_OP_READY_OUT_O)
		else $error("stop request while ready high");
	chk_fly_nostop: assert property (LAUNCH_O && RAMP_ON_FLY_O |-> !STOP_REQ_O)
		else $error("stop request on a flying launch");
endmodule // sdls_sequencer_sva
bind sdls_sequencer sdls_sequencer_sva u_sdls_sequencer_sva (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
	.AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .STORED_OP_READY_OUT_O(STORED_OP_READY_OUT_O),
	.SEQUENCE_BUSY_OUT_O(SEQUENCE_BUSY_OUT_O), .LAUNCH_O(LAUNCH_O), .STOP_REQ_O(STOP_REQ_O),
	.RAMP_ON_FLY_O(RAMP_ON_FLY_O));
`default_nettype wire

// ===== tb/sdls_host_model.sv
/* host controller and profile generator model.
   assumes the sequencer clock; press is called just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module sdls_host_model (
	// clock
	input wire CLK_I,
	// host handshake
	input wire ready_i,
	output logic start_o,
	output logic sequential_start_in_o,
	// profile generator
	input wire launch_i,
	input wire stop_req_i,
	output logic target_o,
	output logic stopped_o
);
	int run_cnt;
	int halt_cnt;
	initial begin
		start_o = 1'b0;
		sequential_start_in_o = 1'b0;
		target_o = 1'b0;
		stopped_o = 1'b1;
		run_cnt = 0;
		halt_cnt = 0;
	end
	// ====
	// motion: target eight cycles after launch, stopped four after stop request
	always @(posedge CLK_I) begin
		target_o <= (run_cnt == 1);
		run_cnt <= (run_cnt > 0) ? run_cnt - 1 : 0;
		halt_cnt <= (halt_cnt > 0) ? halt_cnt - 1 : 0;
		if (launch_i) begin
			run_cnt <= 8;
			stopped_o <= 1'b0;
		end
		if (stop_req_i)
			halt_cnt <= 4;
		if (halt_cnt == 1)
			stopped_o <= 1'b1;
	end
	// ====
	// start or sequential start handshake
	task automatic press(input bit seq, output bit ok);
		int n;
		for (n = 0; n < 300 && ready_i !== 1'b1; n++)
			@(posedge CLK_I);
		if (seq)
			sequential_start_in_o <= 1'b1;
		else
			start_o <= 1'b1;
		for (n = 0; n < 300 && ready_i !== 1'b0; n++)
			@(posedge CLK_I);
		ok = (ready_i === 1'b0);
		start_o <= 1'b0;
		sequential_start_in_o <= 1'b0;
		@(posedge CLK_I);
	endtask
endmodule // sdls_host_model
`default_nettype wire

// ===== tb/sdls_sequencer_tb.sv
/* self-checking testbench of the stored data link sequencer.
   assumes the host model and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`include "sdls_consts.vh"
module sdls_sequencer_tb;
	// ====
	// signals
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic nxt = 1'b0;
	logic evj = 1'b0;
	logic [15:0] dsel = 16'h0000;
	logic [7:0] addr = 8'h00;
	logic [7:0] sel = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic [7:0] entry, acc, dec, last_entry, last_acc, last_dec, stop_dec;
	logic waitreq, start, sequential_start_in, ready, busy, target, stopped, launch, stop_req, ramp, last_ramp;
	int miscompares = 0;
	int checks_done = 0;
	int cyc = 0, rise_cyc = 0, gap = 0, n_launch = 0, n_stop = 0;
	always #10 clk = ~clk;
	sdls_sequencer #(.CYC_PER_MS(5)) u_sdls_sequencer (.CLK_I(clk), .ARST_N_I(arst_n),
		.AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
		.AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
		.START_IN_I(start), .SEQUENTIAL_START_IN_I(sequential_start_in), .NEXT_STEP_IN_I(nxt),
		.STOP_IN_I(1'b0), .BINARY_ENTRY_SELECT_IN_I(sel), .DIRECT_ENTRY_SELECT_IN_I(dsel),
		.STORED_OP_READY_OUT_O(ready), .SEQUENCE_BUSY_OUT_O(busy), .EVENT_JUMP_I(evj),
		.TARGET_REACHED_I(target), .MOTION_STOPPED_I(stopped), .LAUNCH_O(launch),
		.ENTRY_O(entry), .ACCEL_ENTRY_O(acc), .DECEL_ENTRY_O(dec), .STOP_REQ_O(stop_req),
		.RAMP_ON_FLY_O(ramp));
	sdls_host_model u_sdls_host_model (.CLK_I(clk), .ready_i(ready), .start_o(start),
		.sequential_start_in_o(sequential_start_in), .launch_i(launch), .stop_req_i(stop_req), .target_o(target),
		.stopped_o(stopped));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if ($rose(stopped))
			rise_cyc <= cyc;
		if (stop_req) begin
			n_stop <= n_stop + 1;
			stop_dec <= dec;
		end
		if (launch) begin
			n_launch <= n_launch + 1;
			last_dec <= dec;
			last_entry <= entry;
			last_acc <= acc;
			last_ramp <= ramp;
			gap <= cyc - rise_cyc;
		end
	end
	// ====
	// shared tasks
	task automatic end_of_test;
		if (miscompares == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic hang;
		miscompares++;
		end_of_test();
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		for (n = 0; n == 0 || (waitreq !== 1'b0 && n < 50); n++)
			@(posedge clk);
		if (waitreq !== 1'b0)
			hang();
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask
	task automatic tab(input logic [7:0] i, input logic [1:0] lk, input logic [7:0] nx,
		input logic kd, input logic [15:0] dw);
		wr32(`SDLS_REG_TAB_ADDR, 32'(i));
		wr32(`SDLS_REG_TAB_DATA, {4'h0, dw, 1'b0, kd, nx, lk});
	endtask
	task automatic wait_state(input logic r, input logic b);
		int n;
		for (n = 0; n < 3000 && (ready !== r || busy !== b); n++)
			@(posedge clk);
		if (ready !== r || busy !== b)
			hang();
	endtask
	task automatic go(input logic [7:0] s, input bit seq);
		bit ok;
		sel <= s;
		repeat (6) @(posedge clk);
		u_sdls_host_model.press(seq, ok);
		chk(ok, 1'b1);
	endtask
	// ====
	// scenarios
	task automatic s_regs;
		rd_chk(`SDLS_REG_CTRL, `SDLS_CTRL_RESET);
		rd_chk(`SDLS_REG_REMOTE_SEL, `SDLS_REMOTE_RESET);
		rd_chk(8'h1C, 32'h0000_0000);
		rd_chk(`SDLS_REG_STATUS, 32'h0000_0001);
	endtask
	// end-of-chain entries, so no chain runs into an unwritten word
	task automatic s_table;
		tab(8'h02, `SDLS_LINK_NONE, 8'h00, `SDLS_KIND_POSITION, 16'h0000);
		tab(8'h03, `SDLS_LINK_NONE, 8'h00, `SDLS_KIND_POSITION, 16'h0000);
		tab(8'h05, `SDLS_LINK_NONE, 8'h00, `SDLS_KIND_POSITION, 16'h0000);
		tab(8'h0B, `SDLS_LINK_NONE, 8'h00, `SDLS_KIND_POSITION, 16'h0000);
		tab(8'h15, `SDLS_LINK_NONE, 8'h00, `SDLS_KIND_POSITION, 16'h0000);
		tab(8'hFF, `SDLS_LINK_NONE, 8'h00, `SDLS_KIND_VELOCITY, 16'h0000);
		// entry 1f turns the other way
		wr32(`SDLS_REG_TAB_ADDR, 32'h0000_001F);
		wr32(`SDLS_REG_TAB_DATA, 32'h0000_0800);
	endtask
	task automatic s_single;
		int b;
		b = n_launch;
		go(8'h03, 1'b0);
		wait_state(1'b1, 1'b0);
		chk(last_entry, 8'h03);
		chk(n_launch - b, 1);
		go(8'hFF, 1'b1);
		repeat (20) @(posedge clk);
		chk({busy, ready}, 2'b10);
		evj <= 1'b1;
		@(posedge clk);
		evj <= 1'b0;
		wait_state(1'b1, 1'b0);
		chk(last_entry, 8'hFF);
	endtask
	task automatic s_remote;
		wr32(`SDLS_REG_REMOTE_SEL, 32'h0000_0005);
		dsel <= 16'h0004;
		go(8'h03, 1'b0);
		wait_state(1'b1, 1'b0);
		chk(last_entry, 8'h05);
		wr32(`SDLS_REG_REMOTE_SEL, `SDLS_REMOTE_RESET);
		go(8'h03, 1'b0);
		wait_state(1'b1, 1'b0);
		chk(last_entry, 8'h02);
		dsel <= 16'h0006;
		go(8'h03, 1'b0);
		wait_state(1'b1, 1'b0);
		chk(last_entry, 8'h03);
		dsel <= 16'h0000;
	endtask
	task automatic s_manual;
		int b;
		tab(8'h0A, `SDLS_LINK_MANUAL, 8'h0B, `SDLS_KIND_VELOCITY, 16'h0000);
		b = n_launch;
		go(8'h0A, 1'b0);
		repeat (30) @(posedge clk);
		chk({busy, ready}, 2'b10);
		nxt <= 1'b1;
		repeat (8) @(posedge clk);
		nxt <= 1'b0;
		wait_state(1'b1, 1'b1);
		rd_chk(`SDLS_REG_ACTIVE, 32'h0000_000B);
		go(8'h0A, 1'b1);
		wait_state(1'b1, 1'b0);
		chk(last_entry, 8'h0B);
		chk(n_launch - b, 2);
	endtask
	task automatic s_auto;
		int b;
		tab(8'h14, `SDLS_LINK_AUTO, 8'h15, `SDLS_KIND_POSITION, 16'h0002);
		b = n_launch;
		go(8'h14, 1'b0);
		wait_state(1'b1, 1'b0);
		chk(last_entry, 8'h15);
		chk(n_launch - b, 2);
		chk(gap >= 10 && gap < 20, 1'b1);
	endtask
	task automatic s_cont;
		int b;
		tab(8'h1E, `SDLS_LINK_CONT, 8'h1F, `SDLS_KIND_POSITION, 16'h0000);
		b = n_stop;
		go(8'h1E, 1'b0);
		wait_state(1'b1, 1'b0);
		chk(last_entry, 8'h1F);
		chk(last_ramp, 1'b1);
		chk(n_stop - b, 1);
		chk(last_acc, 8'h1F);
		chk(last_dec, 8'h1F);
		chk(stop_dec, 8'h1F);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		repeat (10) @(posedge clk);
		s_regs();
		s_table();
		s_single();
		s_remote();
		s_manual();
		s_auto();
		s_cont();
		end_of_test();
	end
endmodule // sdls_sequencer_tb
`default_nettype wire
